/* rtl/dual_byte_timer_pkg.sv */
/*
 * Constants shared by the dual byte timer with capture: register word indices,
 * control bit positions, reset values and field layouts.
 * Assumes a 32-bit Avalon-MM slave where byte address = 4 * word index.
 */
package dual_byte_timer_pkg;

	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;

	// word indices; byte address is four times the index
	localparam logic [15:0] IDX_TIMER_CONTROL = 16'hfe10;
	localparam logic [15:0] IDX_PRESCALER_MATCH = 16'hfe11;
	localparam logic [15:0] IDX_COUNT_LOW = 16'hfe12;
	localparam logic [15:0] IDX_COUNT_HIGH = 16'hfe13;
	localparam logic [15:0] IDX_MATCH_LOW = 16'hfe14;
	localparam logic [15:0] IDX_MATCH_HIGH = 16'hfe15;
	localparam logic [15:0] IDX_CAPTURE_LOW = 16'hfe16;
	localparam logic [15:0] IDX_CAPTURE_HIGH = 16'hfe17;
	localparam logic [15:0] IDX_INPUT_SELECT = 16'hfe18;
	localparam logic [15:0] IDX_EDGE_CONFIG = 16'hfe19;
	localparam logic [15:0] IDX_AUX_ROUTE = 16'hfe1a;

	// timer_control bit positions
	localparam int BIT_UPPER_RUN = 7;
	localparam int BIT_LOWER_RUN = 6;
	localparam int BIT_CHAIN_SIXTEEN = 5;
	localparam int BIT_LOWER_EXTERNAL_CLOCK = 4;
	localparam int BIT_UPPER_MATCH_FLAG = 3;
	localparam int BIT_UPPER_IRQ_ENABLE = 2;
	localparam int BIT_LOWER_MATCH_FLAG = 1;
	localparam int BIT_LOWER_IRQ_ENABLE = 0;

	// input_select bit positions
	localparam int BIT_UPPER_CAPTURE_PIN_B = 7;
	localparam int BIT_LOWER_CAPTURE_PIN_A = 6;
	localparam int BIT_COUNT_INPUT_SELECT = 0;

	// aux_route bit positions
	localparam int BIT_E_TO_LOWER = 0;
	localparam int BIT_E_TO_UPPER = 1;
	localparam int BIT_F_TO_LOWER = 2;
	localparam int BIT_F_TO_UPPER = 3;
	localparam int BIT_E_PIN_PORT3 = 4;
	localparam int BIT_F_PIN_PORT3 = 5;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] COUNT_WRAP = 8'hff;

	// interrupt vectors of the two requests
	localparam logic [15:0] VECTOR_UPPER = 16'h0023;
	localparam logic [15:0] VECTOR_LOWER = 16'h0013;

endpackage

/* rtl/dbt_event_detect.sv */
/*
 * Pin event detector: two-flop synchroniser, then a selectable rising/falling
 * edge detector giving a single-cycle pulse.
 * Assumes pin is asynchronous to ref_clk and held at least two clocks per level.
 */
`timescale 1ns/10ps
`default_nettype none

module dbt_event_detect (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic pin,
	input wire logic rise_en,
	input wire logic fall_en,
	output logic pulse
);

	logic sync_a;
	logic sync_b;
	logic prev;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			prev <= 1'b0;
		end else begin
			sync_a <= pin;
			sync_b <= sync_a;
			prev <= sync_b;
		end
	end

	// only the second and third stages are compared
	assign pulse = (rise_en & sync_b & ~prev) | (fall_en & ~sync_b & prev); // [RULE_24]

endmodule // dbt_event_detect

`default_nettype wire

/* rtl/dbt_prescaler.sv */
/*
 * Programmable 8-bit prescaler: counts cycle clocks, pulses on compare match.
 * Assumes restart and hold come from logic on ref_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module dbt_prescaler #(
	parameter int WIDTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hold,
	input wire logic restart,
	input wire logic [WIDTH-1:0] prescale_compare,
	output logic match
);

	logic [WIDTH-1:0] count;

	assign match = ~hold & (count == prescale_compare); // [RULE_06]

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (restart || match) begin
			count <= '0; // [RULE_07]
		end else if (!hold) begin
			count <= count + 1'b1; // [RULE_05]
		end
	end

endmodule // dbt_prescaler

`default_nettype wire

/* rtl/dual_byte_timer_capture.sv */
/*
 * Dual byte timer/counter with capture: two 8-bit halves, optional 16-bit
 * chaining, prescaler or external count clock, capture registers, match flags
 * and two interrupt requests, with registers on an Avalon-MM slave.
 * Assumes pins are asynchronous; hold_request and the bus run on ref_clk.
 */
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// [RULE_01] mode 0: two independent prescaled 8-bit timers
// [RULE_02] mode 1: low counts external events, high timer
// [RULE_03] mode 2: chained 16-bit prescaled timer
// [RULE_04] mode 3: chained 16-bit external event counter
// [RULE_05] prescaler advances every cycle except hold
// [RULE_06] prescaler pulses when count equals compare
// [RULE_07] prescaler restarts on match or compare write
// [RULE_08] low half runs only while bit 6
// [RULE_09] bit 4 picks low count clock
// [RULE_10] high half runs only while bit 7
// [RULE_11] bit 5 picks high count clock
// [RULE_12] match on count equal buffer, 16 bits chained
// [RULE_13] half clears when stopped or matched
// [RULE_14] 8-bit modes: low source captures low count
// [RULE_15] 8-bit modes: high source captures high count
// [RULE_16] 16-bit modes: high source captures both
// [RULE_17] enabled interrupt once per half period
// [RULE_18] input select bit 0 picks count pin
// [RULE_19] aux interrupt routing masks port7 capture source
// [RULE_20] buffer tracks when stopped, reloads on match
// [RULE_21] match flags sticky until software clears
// [RULE_22] requests when flag and enable both set
// [RULE_23] 16-bit: equal run bits, flags together
// [RULE_24] detection events are one-cycle synchronous pulses
// [RULE_25] capture keeps count before same-cycle increment
module dual_byte_timer_capture (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hold_request,
	input wire logic port7_pin_a,
	input wire logic port7_pin_b,
	input wire logic port7_pin_c,
	input wire logic port7_pin_d,
	input wire logic port2_pin_a,
	input wire logic port2_pin_b,
	input wire logic port3_pin_a,
	input wire logic port3_pin_b,
	input wire logic [dual_byte_timer_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [dual_byte_timer_pkg::DATA_W-1:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [dual_byte_timer_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	output logic irq_lower,
	output logic irq_upper
);
	import dual_byte_timer_pkg::*;

	localparam int NUM_PINS = 8;

	logic [7:0] timer_control;
	logic [7:0] prescale_compare;
	logic [7:0] lower_half_counter;
	logic [7:0] upper_half_counter;
	logic [7:0] lower_compare_value;
	logic [7:0] upper_compare_value;
	logic [7:0] lower_buffer;
	logic [7:0] upper_buffer;
	logic [7:0] lower_snapshot;
	logic [7:0] upper_snapshot;
	logic [7:0] input_select;
	logic [7:0] edge_config;
	logic [7:0] aux_route;

	logic [NUM_PINS-1:0] pins;
	logic [NUM_PINS-1:0] rise_en;
	logic [NUM_PINS-1:0] fall_en;
	logic [NUM_PINS-1:0] det;

	logic access;
	logic bus_write;
	logic [15:0] word_index;
	logic mapped;
	logic pre_match;
	logic prescaler_restart;

	logic lower_run;
	logic upper_run;
	logic chain_sixteen;
	logic lower_external_clock;
	logic ext_count_evt;
	logic tick_lower;
	logic tick_upper;
	logic match_lower;
	logic match_upper;
	logic ext_e_evt;
	logic ext_f_evt;
	logic route_lower;
	logic route_upper;
	logic cap_lower_src;
	logic cap_upper_src;
	logic cap_lower_evt;
	logic cap_upper_evt;
	logic [7:0] next_readdata;
	logic [7:0] next_control;

	assign lower_run = timer_control[BIT_LOWER_RUN];
	assign upper_run = timer_control[BIT_UPPER_RUN];
	assign chain_sixteen = timer_control[BIT_CHAIN_SIXTEEN];
	assign lower_external_clock = timer_control[BIT_LOWER_EXTERNAL_CLOCK];

	// pin detectors: port7 pins follow edge_config, aux pins use rising edges
	assign pins = {port3_pin_b, port3_pin_a, port2_pin_b, port2_pin_a,
		port7_pin_d, port7_pin_c, port7_pin_b, port7_pin_a};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
			if (gi < 4) begin : g_port7
				assign rise_en[gi] = edge_config[2*gi+1];
				assign fall_en[gi] = edge_config[2*gi];
			end else begin : g_aux
				assign rise_en[gi] = 1'b1;
				assign fall_en[gi] = 1'b0;
			end
			dbt_event_detect u_det (
				.ref_clk(ref_clk),
				.rst(rst),
				.pin(pins[gi]),
				.rise_en(rise_en[gi]),
				.fall_en(fall_en[gi]),
				.pulse(det[gi])
			); // [RULE_24]
		end
	endgenerate

	dbt_prescaler #(
		.WIDTH(8)
	) u_prescaler (
		.ref_clk(ref_clk),
		.rst(rst),
		.hold(hold_request),
		.restart(prescaler_restart),
		.prescale_compare(prescale_compare),
		.match(pre_match)
	); // [RULE_05]

	// external count source: pin d when set, pin c when clear
	assign ext_count_evt = input_select[BIT_COUNT_INPUT_SELECT] ? det[3] : det[2]; // [RULE_18]

	// aux interrupt events, each from port2 or port3
	assign ext_e_evt = aux_route[BIT_E_PIN_PORT3] ? det[6] : det[4];
	assign ext_f_evt = aux_route[BIT_F_PIN_PORT3] ? det[7] : det[5];

	// an aux route replaces the port7 source rather than adding to it
	assign route_lower = aux_route[BIT_E_TO_LOWER] | aux_route[BIT_F_TO_LOWER];
	assign route_upper = aux_route[BIT_E_TO_UPPER] | aux_route[BIT_F_TO_UPPER];
	always_comb begin
		if (route_lower) begin
			cap_lower_src = (aux_route[BIT_E_TO_LOWER] & ext_e_evt) |
				(aux_route[BIT_F_TO_LOWER] & ext_f_evt); // [RULE_19]
		end else begin
			cap_lower_src = input_select[BIT_LOWER_CAPTURE_PIN_A] ? det[0] : det[2];
		end
		if (route_upper) begin
			cap_upper_src = (aux_route[BIT_E_TO_UPPER] & ext_e_evt) |
				(aux_route[BIT_F_TO_UPPER] & ext_f_evt); // [RULE_19]
		end else begin
			cap_upper_src = input_select[BIT_UPPER_CAPTURE_PIN_B] ? det[1] : det[3];
		end
	end

	assign cap_lower_evt = chain_sixteen ? cap_upper_src : cap_lower_src; // [RULE_14] [RULE_16]
	assign cap_upper_evt = cap_upper_src; // [RULE_15] [RULE_16]

	// low count clock: prescaler or external events; chained mode uses it for 16 bits
	assign tick_lower = lower_external_clock ? ext_count_evt : pre_match; // [RULE_09] [RULE_02] [RULE_04]

	// high count clock: prescaler, or low-byte carry when chained
	assign tick_upper = chain_sixteen ? (tick_lower && lower_half_counter == COUNT_WRAP) :
		pre_match; // [RULE_11] [RULE_01] [RULE_03]

	// chained match needs all 16 bits; the high half matches with the low half only while bit 7 is set
	always_comb begin
		if (chain_sixteen) begin
			match_lower = lower_run && tick_lower &&
				{upper_half_counter, lower_half_counter} == {upper_buffer, lower_buffer}; // [RULE_12]
			match_upper = upper_run && match_lower; // [RULE_23]
		end else begin
			match_lower = lower_run && tick_lower && lower_half_counter == lower_buffer; // [RULE_12]
			match_upper = upper_run && pre_match && upper_half_counter == upper_buffer; // [RULE_12]
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lower_half_counter <= RESET_BYTE;
		end else if (!lower_run || match_lower) begin
			lower_half_counter <= RESET_BYTE; // [RULE_08] [RULE_13]
		end else if (tick_lower) begin
			lower_half_counter <= lower_half_counter + 8'h01;
		end
	end

	// chained mode still gates the upper byte by its own run bit
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			upper_half_counter <= RESET_BYTE;
		end else if (!upper_run || match_upper) begin
			upper_half_counter <= RESET_BYTE; // [RULE_10] [RULE_13]
		end else if (tick_upper) begin
			upper_half_counter <= upper_half_counter + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lower_buffer <= RESET_BYTE;
			upper_buffer <= RESET_BYTE;
		end else begin
			if (!lower_run || match_lower) begin
				lower_buffer <= lower_compare_value; // [RULE_20]
			end
			if (!upper_run || match_upper) begin
				upper_buffer <= upper_compare_value; // [RULE_20]
			end
		end
	end

	// snapshot takes the pre-increment value of the same cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lower_snapshot <= RESET_BYTE;
			upper_snapshot <= RESET_BYTE;
		end else begin
			if (cap_lower_evt) begin
				lower_snapshot <= lower_half_counter; // [RULE_25] [RULE_14]
			end
			if (cap_upper_evt) begin
				upper_snapshot <= upper_half_counter; // [RULE_25] [RULE_15]
			end
		end
	end

	// bus: request seen with waitrequest high, answered one clock later
	assign access = (read | write) & ~waitrequest;
	assign bus_write = write & ~waitrequest & byteenable[0];
	assign word_index = address[ADDR_W-1:2];
	assign prescaler_restart = bus_write && mapped && word_index == IDX_PRESCALER_MATCH; // [RULE_07]

	always_comb begin
		mapped = (address[1:0] == 2'b00);
		next_readdata = RESET_BYTE;
		case (word_index)
			IDX_TIMER_CONTROL: next_readdata = timer_control;
			IDX_PRESCALER_MATCH: next_readdata = prescale_compare;
			IDX_COUNT_LOW: next_readdata = lower_half_counter;
			IDX_COUNT_HIGH: next_readdata = upper_half_counter;
			IDX_MATCH_LOW: next_readdata = lower_compare_value;
			IDX_MATCH_HIGH: next_readdata = upper_compare_value;
			IDX_CAPTURE_LOW: next_readdata = lower_snapshot;
			IDX_CAPTURE_HIGH: next_readdata = upper_snapshot;
			IDX_INPUT_SELECT: next_readdata = input_select;
			IDX_EDGE_CONFIG: next_readdata = edge_config;
			IDX_AUX_ROUTE: next_readdata = aux_route;
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			waitrequest <= 1'b1;
			readdata <= '0;
		end else begin
			waitrequest <= ~((read | write) & waitrequest);
			if (read && waitrequest) begin
				readdata <= {24'h00_0000, mapped ? next_readdata : RESET_BYTE};
			end
		end
	end

	// hardware set wins over a software clear in the same cycle
	always_comb begin
		next_control = timer_control;
		if (bus_write && mapped && word_index == IDX_TIMER_CONTROL) begin
			next_control = writedata[7:0];
		end
		if (match_upper) begin
			next_control[BIT_UPPER_MATCH_FLAG] = 1'b1; // [RULE_21]
		end
		if (match_lower) begin
			next_control[BIT_LOWER_MATCH_FLAG] = 1'b1; // [RULE_21] [RULE_23]
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer_control <= RESET_BYTE;
		end else begin
			timer_control <= next_control;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prescale_compare <= RESET_BYTE;
			lower_compare_value <= RESET_BYTE;
			upper_compare_value <= RESET_BYTE;
			input_select <= RESET_BYTE;
			edge_config <= RESET_BYTE;
			aux_route <= RESET_BYTE;
		end else if (bus_write && mapped) begin
			case (word_index)
				IDX_PRESCALER_MATCH: prescale_compare <= writedata[7:0];
				IDX_MATCH_LOW: lower_compare_value <= writedata[7:0];
				IDX_MATCH_HIGH: upper_compare_value <= writedata[7:0];
				IDX_INPUT_SELECT: input_select <= writedata[7:0];
				IDX_EDGE_CONFIG: edge_config <= writedata[7:0];
				IDX_AUX_ROUTE: aux_route <= writedata[7:0];
				default: ;
			endcase
		end
	end

	// requests registered beside the flags, so they rise at the same edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_lower <= 1'b0;
			irq_upper <= 1'b0;
		end else begin
			irq_lower <= next_control[BIT_LOWER_MATCH_FLAG] & next_control[BIT_LOWER_IRQ_ENABLE]; // [RULE_22] [RULE_17]
			irq_upper <= next_control[BIT_UPPER_MATCH_FLAG] & next_control[BIT_UPPER_IRQ_ENABLE]; // [RULE_22] [RULE_17]
		end
	end

	// access feeds no logic, not even the decode, but marks the accepting edge
	logic unused_access;
	assign unused_access = access;

endmodule // dual_byte_timer_capture

`default_nettype wire

/* tb/dual_byte_timer_capture_checker.sv */
/*
 * Checker for the dual byte timer: bus handshake timing, read data and irq levels.
 * Assumes it sees only the top ports; it is bound to every instance.
 */
`timescale 1ns/10ps
`default_nettype none

module dual_byte_timer_capture_checker
	import dual_byte_timer_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [dual_byte_timer_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [dual_byte_timer_pkg::DATA_W-1:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [dual_byte_timer_pkg::DATA_W-1:0] readdata,
	input wire logic waitrequest,
	input wire logic irq_lower,
	input wire logic irq_upper
);
	logic ctl_wr;
	logic unmapped;
	// a control write lands at the edge where waitrequest is seen low
	assign ctl_wr = write && !waitrequest && byteenable[0] && address == {IDX_TIMER_CONTROL, 2'b00};
	assign unmapped = address[1:0] != 2'b00 || address[17:2] < IDX_TIMER_CONTROL || address[17:2] > IDX_AUX_ROUTE;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("no answer one cycle after request");
	a_wait_single: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low too long");
	a_wait_idle: assert property (!read && !write |=> waitrequest)
		else $error("answer without request");
	a_read_upper: assert property (read && !waitrequest |-> readdata[31:8] == 24'h00_0000)
		else $error("upper read data not zero");
	a_read_unmapped: assert property (read && !waitrequest && unmapped |-> readdata == '0)
		else $error("unmapped read not zero");
	a_irq_low_off: assert property (ctl_wr && !writedata[BIT_LOWER_IRQ_ENABLE] |=> !irq_lower)
		else $error("lower irq without enable");
	a_irq_low_on: assert property (ctl_wr && writedata[1] && writedata[0] |=> irq_lower)
		else $error("lower irq missing");
	a_irq_up_off: assert property (ctl_wr && !writedata[BIT_UPPER_IRQ_ENABLE] |=> !irq_upper)
		else $error("upper irq without enable");
	a_irq_up_on: assert property (ctl_wr && writedata[3] && writedata[2] |=> irq_upper)
		else $error("upper irq missing");
	a_flag_sticky: assert property ($fell(irq_lower) |-> $past(ctl_wr))
		else $error("lower irq dropped without write");
	cover property (ctl_wr);
	cover property ($rose(irq_lower));
	cover property ($rose(irq_upper));
endmodule // dual_byte_timer_capture_checker

bind dual_byte_timer_capture dual_byte_timer_capture_checker dual_byte_timer_capture_checker_i (.ref_clk, .rst,
	.address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .irq_lower, .irq_upper);

`default_nettype wire

/* tb/pin_event_source.sv */
/*
 * Far side model: port pins that produce count and capture events.
 * Assumes idle-low pins; each strike holds a level four clocks, past the sync depth.
 */
`timescale 1ns/10ps
`default_nettype none

module pin_event_source (
	input wire logic ref_clk,
	output logic [7:0] pins
);
	initial pins = 8'h00;

	task automatic strike(input int n);
		pins[n] <= 1'b1;
		repeat (4) @(posedge ref_clk);
		pins[n] <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask
endmodule // pin_event_source

`default_nettype wire

/* tb/dual_byte_timer_capture_tb.sv */
/*
 * Testbench for the dual byte timer: registers, periods, hold, external counts, captures.
 * Assumes the pin model drives port7 a..d on pins[3:0] and aux pins on pins[7:4].
 */
`timescale 1ns/10ps
`default_nettype none

module dual_byte_timer_capture_tb;
	import dual_byte_timer_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic hold_request = 1'b0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [ADDR_W-1:0] address = '0;
	logic [DATA_W-1:0] writedata = '0;
	logic [3:0] byteenable = 4'h0;
	logic [DATA_W-1:0] readdata;
	logic waitrequest;
	logic irq_lower;
	logic irq_upper;
	logic [7:0] pins;
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;

	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;

	dual_byte_timer_capture dual_byte_timer_capture_i (.ref_clk, .rst, .hold_request, .port7_pin_a(pins[0]),
		.port7_pin_b(pins[1]), .port7_pin_c(pins[2]), .port7_pin_d(pins[3]), .port2_pin_a(pins[4]),
		.port2_pin_b(pins[5]), .port3_pin_a(pins[6]), .port3_pin_b(pins[7]), .address, .read, .write,
		.writedata, .byteenable, .readdata, .waitrequest, .irq_lower, .irq_upper);
	pin_event_source pin_event_source_i (.ref_clk, .pins);

	task automatic conclude;
		if (fail_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// request held until waitrequest is sampled low, then released
	task automatic bus(input logic wr_en, input logic [15:0] idx, input logic [7:0] d, input logic [3:0] be,
		output logic [7:0] q);
		address <= {idx, 2'b00};
		writedata <= {24'h00_0000, d};
		byteenable <= be;
		read <= !wr_en;
		write <= wr_en;
		// no local limit: a stuck slave is left to the watchdog
		do begin
			@(posedge ref_clk);
		end while (waitrequest !== 1'b0);
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, idx, d, 4'h1, q);
	endtask

	task automatic rd(input logic [15:0] idx, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, idx, 8'h00, 4'h1, q);
		chk(q, e);
	endtask

	task automatic wait_irq(input bit up, input int lim, output int t);
		int n;
		n = 0;
		while ((up ? irq_upper : irq_lower) !== 1'b1 && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		chk(up ? irq_upper : irq_lower, 1);
		t = cyc;
	endtask

	task automatic reset_values;
		logic [7:0] q;
		for (int i = 0; i < 8; i++)
			rd(16'(IDX_TIMER_CONTROL + i), 8'h00);
		wr(IDX_COUNT_LOW, 8'h55);
		rd(IDX_COUNT_LOW, 8'h00);
		bus(1'b1, IDX_MATCH_LOW, 8'h77, 4'h0, q);
		rd(IDX_MATCH_LOW, 8'h00);
		rd(16'hfe1b, 8'h00);
	endtask

	// software flag set, enables gate the requests
	task automatic flags_by_software;
		wr(IDX_TIMER_CONTROL, 8'h0f);
		rd(IDX_TIMER_CONTROL, 8'h0f);
		chk({irq_upper, irq_lower}, 2'b11);
		wr(IDX_TIMER_CONTROL, 8'h0a);
		repeat (2) @(posedge ref_clk);
		chk({irq_upper, irq_lower}, 2'b00);
		wr(IDX_TIMER_CONTROL, 8'h00);
	endtask

	// distance between two matches; hold cycles stretch it
	task automatic period(input logic [7:0] ctl, input bit up, input int hold, input int exp);
		int t1;
		int t2;
		wr(IDX_TIMER_CONTROL, ctl);
		wait_irq(up, 3000, t1);
		repeat (hold) begin
			hold_request <= 1'b1;
			@(posedge ref_clk);
		end
		hold_request <= 1'b0;
		wr(IDX_TIMER_CONTROL, ctl);
		repeat (2) @(posedge ref_clk);
		wait_irq(up, 3000, t2);
		chk(t2 - t1, exp);
		wr(IDX_TIMER_CONTROL, 8'h00);
	endtask

	// third event on the chosen pin matches a compare value of 2
	task automatic ext_count(input logic [7:0] isel, input int pin);
		int t;
		wr(IDX_INPUT_SELECT, isel);
		wr(IDX_MATCH_LOW, 8'h02);
		wr(IDX_TIMER_CONTROL, 8'h51);
		repeat (2) pin_event_source_i.strike(pin);
		chk(irq_lower, 0);
		pin_event_source_i.strike(pin);
		wait_irq(1'b0, 20, t);
		// with pin c as both count and capture source, the matching event keeps 2
		rd(IDX_CAPTURE_LOW, 8'h02);
		wr(IDX_TIMER_CONTROL, 8'h00);
	endtask

	task automatic capture;
		wr(IDX_INPUT_SELECT, 8'hc0);
		wr(IDX_MATCH_LOW, 8'h09);
		wr(IDX_TIMER_CONTROL, 8'h50);
		repeat (2) pin_event_source_i.strike(2);
		pin_event_source_i.strike(0);
		rd(IDX_CAPTURE_LOW, 8'h02);
		pin_event_source_i.strike(2);
		wr(IDX_AUX_ROUTE, 8'h01);
		pin_event_source_i.strike(0);
		rd(IDX_CAPTURE_LOW, 8'h02);
		pin_event_source_i.strike(4);
		rd(IDX_CAPTURE_LOW, 8'h03);
		wr(IDX_AUX_ROUTE, 8'h00);
		wr(IDX_TIMER_CONTROL, 8'h00);
		wr(IDX_MATCH_LOW, 8'hff);
		wr(IDX_MATCH_HIGH, 8'hff);
		wr(IDX_TIMER_CONTROL, 8'hf0);
		repeat (3) pin_event_source_i.strike(2);
		pin_event_source_i.strike(1);
		rd(IDX_CAPTURE_LOW, 8'h03);
		rd(IDX_CAPTURE_HIGH, 8'h00);
		wr(IDX_TIMER_CONTROL, 8'h00);
	endtask

	initial begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		reset_values();
		flags_by_software();
		wr(IDX_EDGE_CONFIG, 8'haa);
		wr(IDX_PRESCALER_MATCH, 8'h03);
		wr(IDX_MATCH_LOW, 8'h02);
		wr(IDX_MATCH_HIGH, 8'h04);
		period(8'h41, 1'b0, 10, 22);
		period(8'h84, 1'b1, 0, 20);
		wr(IDX_MATCH_LOW, 8'h01);
		wr(IDX_MATCH_HIGH, 8'h01);
		period(8'he5, 1'b1, 0, 1032);
		ext_count(8'h80, 2);
		ext_count(8'hc1, 3);
		capture();
		conclude();
	end

	// whole run is a few thousand cycles
	initial begin
		#200_000;
		fail_count++;
		conclude();
	end
endmodule // dual_byte_timer_capture_tb

`default_nettype wire
